/* File: pif_evt_model.sv */
// event source model: pulses a chosen set of peripheral events
`timescale 1ns/1ns
module pif_evt_model import pif_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fire,
  input wire pif_events_s pattern,
  output pif_events_s events
);
  // one-cycle pulses, so a later clear by software is not undone by a held level
  always_ff @(posedge aclk) begin
    if (!aresetn) events <= '0;
    else events <= fire ? pattern : '0;
  end
endmodule : pif_evt_model

/* File: pif_flag_bank.sv */
// one flag register: event set, software write, unimplemented bits held at zero
`timescale 1ns/1ns
module pif_flag_bank import pif_pkg::*; #(
  parameter logic [7:0] IMPL_MASK = 8'hFF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] event_in,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] flags
);

  logic [7:0] flags_reg;
  logic [7:0] flags_next;

  // a software write lands first, then events set on top so none is lost
  always_comb begin
    flags_next = flags_reg;
    if (wr_en) begin
      flags_next = wr_data;
    end
    flags_next = (flags_next | event_in) & IMPL_MASK;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= PIF_RESET_BYTE;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule : pif_flag_bank

/* File: pif_irq_flags.sv */
// top: peripheral interrupt flags and enables behind an axi4-lite slave
// Summary of operation
// - events set flags regardless of any enable
// - second flag register bit layout
// - unimplemented flag bits always read zero
// - third flag register bit layout
// - flags readable, writable, one means pending
// - all flags reset to zero
// - enable bits mirror flags; global, peripheral enables
// - peripheral enable gates every peripheral request
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module pif_irq_flags import pif_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic osc_fail_evt,
  input wire logic comparator_two_evt,
  input wire logic comparator_one_evt,
  input wire logic nv_write_done_evt,
  input wire logic bus_collision_evt,
  input wire logic display_module_evt,
  input wire logic capcomp_two_evt,
  input wire logic capcomp_five_evt,
  input wire logic capcomp_four_evt,
  input wire logic capcomp_three_evt,
  input wire logic timer_six_match_evt,
  input wire logic timer_four_match_evt,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic periph_irq_req,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode helper, shared by read and write paths

  function automatic logic pif_mapped(input logic [7:0] a);
    case (a)
      PIF_OFF_CONTROL, PIF_OFF_EN_TWO, PIF_OFF_EN_THREE, PIF_OFF_FLAGS_TWO,
      PIF_OFF_FLAGS_THREE, PIF_OFF_IRQ_STATUS, PIF_OFF_IRQ_MASK: pif_mapped = 1'b1;
      default: pif_mapped = 1'b0;
    endcase
  endfunction : pif_mapped

  ////////////////////////////////////////////////////////////////////////////
  // event gathering into register layout

  pif_events_s events;

  // packing puts each source at its documented bit
  always_comb begin
    events.two = {osc_fail_evt, comparator_two_evt, comparator_one_evt, nv_write_done_evt,
                  bus_collision_evt, display_module_evt, 1'b0, capcomp_two_evt};
    events.three = {1'b0, capcomp_five_evt, capcomp_four_evt, capcomp_three_evt,
                    timer_six_match_evt, 1'b0, timer_four_match_evt, 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order

  logic [7:0] awaddr_reg;
  logic aw_held_reg;
  logic [7:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  pif_wr_s wr;
  logic wr_fire;

  // each channel is accepted once, then held until the write fires with both halves in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 8'h00;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata[7:0];
      wstrb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // ready only while the slot is empty and no response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !bvalid_reg
                       && !wr_fire;
      s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !bvalid_reg
                      && !wr_fire;
    end
  end

  // slots are freed on every completed pair, strobe or not, else the bus would lock up
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

  // write commits when both halves are held; only byte lane 0 carries data
  always_comb begin
    wr.en = wr_fire && wstrb_reg[0];
    wr.addr = awaddr_reg;
    wr.data = wdata_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= PIF_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= pif_mapped(awaddr_reg) ? PIF_RESP_OKAY : PIF_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin // only a real handshake retires it
      bvalid_reg <= 1'b0;
    end
  end

  // a strobe without lane 0 still completes, it just changes nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PIF_RESP_OKAY;
    end else begin
      s_axi_bvalid <= bvalid_reg && !(s_axi_bvalid && s_axi_bready);
      s_axi_bresp <= bresp_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable and control registers

  logic [7:0] control_reg;
  logic [7:0] enable_two_reg;
  logic [7:0] enable_three_reg;
  logic [1:0] irq_mask_reg;

  // enables share the flag layout, so unimplemented positions stay zero too
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_reg <= PIF_RESET_BYTE;
      enable_two_reg <= PIF_RESET_BYTE;
      enable_three_reg <= PIF_RESET_BYTE;
      irq_mask_reg <= PIF_RESET_STATUS;
    end else if (wr.en) begin
      case (wr.addr)
        PIF_OFF_CONTROL: control_reg <= wr.data & PIF_CONTROL_MASK;
        PIF_OFF_EN_TWO: enable_two_reg <= wr.data & PIF_FLAGS_TWO_MASK;
        PIF_OFF_EN_THREE: enable_three_reg <= wr.data & PIF_FLAGS_THREE_MASK;
        PIF_OFF_IRQ_MASK: irq_mask_reg <= wr.data[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag registers

  logic [7:0] flags_two;
  logic [7:0] flags_three;

  pif_flag_bank #(.IMPL_MASK(PIF_FLAGS_TWO_MASK)) u_flags_two (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_in(events.two),
    .wr_en(wr.en && wr.addr == PIF_OFF_FLAGS_TWO),
    .wr_data(wr.data),
    .flags(flags_two)
  );

  pif_flag_bank #(.IMPL_MASK(PIF_FLAGS_THREE_MASK)) u_flags_three (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_in(events.three),
    .wr_en(wr.en && wr.addr == PIF_OFF_FLAGS_THREE),
    .wr_data(wr.data),
    .flags(flags_three)
  );

  ////////////////////////////////////////////////////////////////////////////
  // peripheral request toward the core

  logic req_now;
  logic req_prev_reg;

  // relies on software clearing stale flags before enabling, else it fires at once
  assign req_now = control_reg[PIF_BIT_GLOBAL_EN] && control_reg[PIF_BIT_PERIPH_EN]
                   && (|(flags_two & enable_two_reg) || |(flags_three & enable_three_reg));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_irq_req <= 1'b0;
      req_prev_reg <= 1'b0;
    end else begin
      periph_irq_req <= req_now;
      req_prev_reg <= req_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, write one to clear; set wins over clear

  logic [1:0] status_reg;
  logic [1:0] status_set;
  logic [1:0] status_clr;

  always_comb begin
    status_set = 2'b00;
    status_set[PIF_ST_REQ_RISE] = req_now && !req_prev_reg;
    status_set[PIF_ST_EVT_SEEN] = |events.two || |events.three;
    status_clr = (wr.en && wr.addr == PIF_OFF_IRQ_STATUS) ? wr.data[1:0] : 2'b00;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= PIF_RESET_STATUS;
    end else begin
      status_reg <= (status_reg & ~status_clr) | status_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status_reg & ~status_clr) | status_set) & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  logic [7:0] rd_byte;

  // unimplemented bits are zero in storage, so reads show zero there
  always_comb begin
    case (s_axi_araddr)
      PIF_OFF_CONTROL: rd_byte = control_reg;
      PIF_OFF_EN_TWO: rd_byte = enable_two_reg;
      PIF_OFF_EN_THREE: rd_byte = enable_three_reg;
      PIF_OFF_FLAGS_TWO: rd_byte = flags_two;
      PIF_OFF_FLAGS_THREE: rd_byte = flags_three;
      PIF_OFF_IRQ_STATUS: rd_byte = {6'h00, status_reg};
      PIF_OFF_IRQ_MASK: rd_byte = {6'h00, irq_mask_reg};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= PIF_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= pif_mapped(s_axi_araddr) ? PIF_RESP_OKAY : PIF_RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : pif_irq_flags

/* File: pif_irq_flags_properties.sv */
// checker: bus timing and read values seen at the flag block ports
`timescale 1ns/1ns
module pif_irq_flags_properties import pif_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic periph_irq_req,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] ra_q;
  // one read in flight at most, so one address slot is enough
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
  end
  ////////////////////////////////////////
  rst_quiet_a: assert property (disable iff (1'b0)
    !aresetn |=> !periph_irq_req && !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("output active after reset");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  read_turn_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  two_unimpl_a: assert property (s_axi_rvalid && ra_q == PIF_OFF_FLAGS_TWO |->
    (s_axi_rdata & 32'hFFFF_FF02) == 32'h0000_0000) else $error("flag two spare bit set");
  three_unimpl_a: assert property (s_axi_rvalid && ra_q == PIF_OFF_FLAGS_THREE |->
    (s_axi_rdata & 32'hFFFF_FF85) == 32'h0000_0000) else $error("flag three spare bit set");
  ctl_bits_a: assert property (s_axi_rvalid && ra_q == PIF_OFF_CONTROL |->
    (s_axi_rdata & 32'hFFFF_FF3F) == 32'h0000_0000) else $error("control spare bit set");
  unmapped_a: assert property (s_axi_rvalid && ra_q > 8'h18 |->
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000) else $error("unmapped read answered");
  cover property (s_axi_bvalid && !s_axi_bready);
  cover property ($rose(periph_irq_req));
  cover property ($rose(irq));
endmodule : pif_irq_flags_properties
bind pif_irq_flags pif_irq_flags_properties i_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .periph_irq_req(periph_irq_req), .irq(irq));

/* File: pif_irq_flags_test.sv */
// self-checking bench for the peripheral flag block
`timescale 1ns/1ns
module pif_irq_flags_test import pif_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic fire = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, req, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  pif_events_s pat = '0;
  pif_events_s ev;
  int num_errors = 0;
  int num_checks = 0;
  initial begin
    forever #5 aclk = ~aclk;
  end
  pif_evt_model i_src (.aclk(aclk), .aresetn(aresetn), .fire(fire), .pattern(pat), .events(ev));
  pif_irq_flags i_dut (.aclk(aclk), .aresetn(aresetn), .osc_fail_evt(ev.two[7]),
    .comparator_two_evt(ev.two[6]), .comparator_one_evt(ev.two[5]),
    .nv_write_done_evt(ev.two[4]), .bus_collision_evt(ev.two[3]),
    .display_module_evt(ev.two[2]), .capcomp_two_evt(ev.two[0]),
    .capcomp_five_evt(ev.three[6]), .capcomp_four_evt(ev.three[5]),
    .capcomp_three_evt(ev.three[4]), .timer_six_match_evt(ev.three[3]),
    .timer_four_match_evt(ev.three[1]), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .periph_irq_req(req), .irq(irq));
  ////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // bready goes up with the request and stays until the response is taken
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
    output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // no answer time is assumed; only the watchdog ends a hung wait
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] rr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    rr = rresp;
    rready <= 1'b0;
    chk(d, e);
    chk(32'(rr), (a > 8'h18) ? 32'h0000_0002 : 32'h0000_0000);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, 4'hF, r);
    chk(32'(r), (a > 8'h18) ? 32'h0000_0002 : 32'h0000_0000);
  endtask : wr
  task automatic pulse(input pif_events_s p);
    @(posedge aclk);
    fire <= 1'b1;
    pat <= p;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : pulse
  // let the last edge's updates land before looking at the levels
  task automatic pins(input logic [1:0] e);
    @(posedge aclk);
    #1;
    chk(32'({req, irq}), 32'(e));
  endtask : pins
  ////////////////////////////////////////
  task automatic t_zero();
    for (int a = 0; a <= 24; a += 4) rd(8'(a), 32'h0000_0000);
    pins(2'b00);
  endtask : t_zero
  task automatic t_layout();
    logic [15:0] e;
    for (int i = 0; i < 16; i++) begin
      e = 16'hFD7A & (16'h0001 << i);
      pulse(16'h0001 << i);
      rd(PIF_OFF_FLAGS_TWO, 32'(e[15:8]));
      rd(PIF_OFF_FLAGS_THREE, 32'(e[7:0]));
      pins(2'b00);
      wr(PIF_OFF_FLAGS_TWO, 8'h00);
      wr(PIF_OFF_FLAGS_THREE, 8'h00);
    end
  endtask : t_layout
  task automatic t_soft();
    wr(PIF_OFF_FLAGS_THREE, 8'hFF);
    rd(PIF_OFF_FLAGS_THREE, 32'h0000_007A);
    wr(PIF_OFF_FLAGS_THREE, 8'h00);
    wr(PIF_OFF_EN_TWO, 8'hFF);
    wr(PIF_OFF_EN_THREE, 8'hFF);
    wr(PIF_OFF_CONTROL, 8'hFF);
    rd(PIF_OFF_EN_TWO, 32'h0000_00FD);
    rd(PIF_OFF_EN_THREE, 32'h0000_007A);
    rd(PIF_OFF_CONTROL, 32'h0000_00C0);
    wr(PIF_OFF_EN_THREE, 8'h00);
  endtask : t_soft
  // only an enabled flag under both enables may raise the request
  task automatic t_req();
    wr(PIF_OFF_FLAGS_TWO, 8'h00);
    wr(PIF_OFF_EN_TWO, 8'h10);
    pulse(16'h0100);
    pins(2'b00);
    pulse(16'h1000);
    pins(2'b10);
    wr(PIF_OFF_CONTROL, 8'h80);
    pins(2'b00);
    wr(PIF_OFF_CONTROL, 8'hC0);
    pins(2'b10);
    wr(PIF_OFF_CONTROL, 8'h40);
    pins(2'b00);
    wr(PIF_OFF_CONTROL, 8'hC0);
    wr(PIF_OFF_FLAGS_TWO, 8'h00);
    pins(2'b00);
  endtask : t_req
  task automatic t_irq();
    wr(PIF_OFF_IRQ_STATUS, 8'h03);
    wr(PIF_OFF_IRQ_MASK, 8'h02);
    pins(2'b00);
    pulse(16'h0002);
    pins(2'b01);
    wr(PIF_OFF_IRQ_MASK, 8'h00);
    pins(2'b00);
    wr(PIF_OFF_IRQ_MASK, 8'h01);
    wr(PIF_OFF_IRQ_STATUS, 8'h02);
    pulse(16'h1000);
    pins(2'b11);
    rd(PIF_OFF_IRQ_STATUS, 32'h0000_0003);
    wr(PIF_OFF_IRQ_STATUS, 8'h03);
    pins(2'b10);
  endtask : t_irq
  task automatic t_bus();
    logic [1:0] r;
    rd(8'h1C, 32'h0000_0000);
    wr(8'h1C, 8'hFF);
    axi_wr(PIF_OFF_CONTROL, 8'h00, 4'h0, r);
    chk(32'(r), 32'h0000_0000);
    rd(PIF_OFF_CONTROL, 32'h0000_00C0);
    // a write without lane 0 must still free the slots, so the next one lands
    wr(PIF_OFF_CONTROL, 8'h40);
    rd(PIF_OFF_CONTROL, 32'h0000_0040);
  endtask : t_bus
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_zero();
    t_layout();
    t_soft();
    t_req();
    t_irq();
    t_bus();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_zero();
    complete_run();
  end
  // a hung handshake ends the run here
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    complete_run();
  end
endmodule : pif_irq_flags_test

/* File: pif_pkg.sv */
// package: register map, field positions and bus types for the peripheral flag block
package pif_pkg;

  // register byte addresses
  localparam logic [7:0] PIF_OFF_CONTROL = 8'h00;
  localparam logic [7:0] PIF_OFF_EN_TWO = 8'h04;
  localparam logic [7:0] PIF_OFF_EN_THREE = 8'h08;
  localparam logic [7:0] PIF_OFF_FLAGS_TWO = 8'h0C;
  localparam logic [7:0] PIF_OFF_FLAGS_THREE = 8'h10;
  localparam logic [7:0] PIF_OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] PIF_OFF_IRQ_MASK = 8'h18;

  // control register fields
  localparam int PIF_BIT_GLOBAL_EN = 7;
  localparam int PIF_BIT_PERIPH_EN = 6;
  localparam logic [7:0] PIF_CONTROL_MASK = 8'hC0;

  // implemented flag positions in each flag register
  localparam logic [7:0] PIF_FLAGS_TWO_MASK = 8'hFD;
  localparam logic [7:0] PIF_FLAGS_THREE_MASK = 8'h7A;

  // reset values
  localparam logic [7:0] PIF_RESET_BYTE = 8'h00;
  localparam logic [1:0] PIF_RESET_STATUS = 2'h0;

  // sticky status bits
  localparam int PIF_ST_REQ_RISE = 0;
  localparam int PIF_ST_EVT_SEEN = 1;

  // axi response codes
  localparam logic [1:0] PIF_RESP_OKAY = 2'h0;
  localparam logic [1:0] PIF_RESP_SLVERR = 2'h2;

  // event sources grouped per flag register
  typedef struct packed {
    logic [7:0] two;
    logic [7:0] three;
  } pif_events_s;

  // one register write, as seen by the flag core
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } pif_wr_s;

endpackage : pif_pkg
